/* File: rtl/leb_error_baud.sv */
// lin error flags, length decode, checksum check and bit-rate generator behind an avalon slave
`timescale 1ns/100ps
module leb_error_baud
   import leb_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          arst_n,
   input  wire logic [5:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output logic      [31:0]   avs_readdata,
   output logic               avs_waitrequest,
   input  wire leb_frame_ev_t frame_ev,
   input  wire logic          lin_rx,
   output leb_cfg_t           cfg
);
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   function automatic logic [3:0] decode_len(input logic [3:0] code, input logic [5:0] id);
      logic [3:0] n;
      n = code;
      if (code == LEN_FROM_ID) begin
         case (id[5:4])
            2'b10:   n = LEN_FOUR;
            2'b11:   n = LEN_MAX;
            default: n = LEN_TWO;
         endcase
      end else if (code > LEN_MAX) begin
         // reserved codes: treated as the longest field rather than left undefined
         n = LEN_MAX;
      end
      return n;
   endfunction : decode_len

   function automatic logic [7:0] max_frame(input logic [3:0] n);
      int bits;
      bits = ((HDR_BITS + BYTE_BITS * (int'(n) + 1)) * TOL_NUM) / TOL_DEN;
      return bits[7:0];
   endfunction : max_frame

   function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[7:0] + {7'h00, t[8]};
   endfunction : add_carry

   leb_state_t s;
   leb_state_t next_s;

   logic       req;
   logic       take;
   logic       word_ok;
   logic [3:0] idx;
   logic       clr;
   logic [4:0] set_err;
   logic [3:0] len;
   logic [8:0] divider;
   logic [5:0] step;
   logic [2:0] pre_lim;
   logic [9:0] acc_sum;
   logic [7:0] rd_mux;
   logic [7:0] wbyte;

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~s.ack;
   assign take            = req & s.ack;
   assign idx             = avs_address[5:2];
   assign word_ok         = avs_address[1:0] == WORD_ALIGN;
   assign wbyte           = avs_writedata[7:0];
   assign avs_readdata    = {24'h000000, s.rdata};

   always_comb begin
      divider = {s.scale[0], s.divlo};
      step    = s.slave ? 6'h01 : {1'b0, s.scale[5:1]} + 6'h01;
      pre_lim = 3'((4'h1 << s.scale[7:6]) - 4'h1);
      acc_sum = s.acc + {4'h0, step};
      len     = decode_len(s.size[3:0], s.id);
      clr     = take & avs_write & word_ok & avs_byteenable[0] & (idx == IDX_CTRL) & wbyte[CTL_CLR];
      case (idx)
         IDX_CTRL:   rd_mux = {s.stop, 2'h0, s.data_acknowledge_bit, 3'h0, s.slave};
         IDX_STATUS: rd_mux = {5'h00, s.err_sum, 2'h0};
         IDX_ERR:    rd_mux = {3'h0, s.errf};
         IDX_SIZE:   rd_mux = {s.size[SIZE_ENH], 3'h0, s.size[3:0]};
         IDX_DIV:    rd_mux = s.divlo;
         IDX_SCALE:  rd_mux = s.scale;
         IDX_ID:     rd_mux = {2'h0, s.id};
         default:    rd_mux = 8'h00;
      endcase
      if (!word_ok) begin
         rd_mux = 8'h00;
      end
   end

   always_comb begin
      next_s          = s;
      set_err         = 5'h00;
      next_s.ack      = req & ~s.ack;
      next_s.bit_tick = 1'b0;
      if (req && !s.ack && avs_read) begin
         next_s.rdata = rd_mux;
      end
      if (take && avs_write && word_ok && avs_byteenable[0]) begin
         case (idx)
            IDX_CTRL: begin
               next_s.stop  = wbyte[CTL_STOP];
               next_s.data_acknowledge_bit = wbyte[CTL_DATA_ACKNOWLEDGE_BIT];
               next_s.slave = wbyte[CTL_SLAVE];
            end
            IDX_SIZE:  next_s.size  = {wbyte[SIZE_ENH], 3'h0, wbyte[3:0]};
            IDX_DIV:   next_s.divlo = wbyte;
            IDX_SCALE: next_s.scale = wbyte;
            IDX_ID:    next_s.id    = wbyte[5:0];
            default:   next_s.id    = s.id;
         endcase
      end

      if (s.pre_cnt >= pre_lim) begin
         next_s.pre_cnt = 3'h0;
         if (acc_sum >= {1'b0, divider}) begin
            next_s.acc      = acc_sum - {1'b0, divider};
            next_s.bit_tick = 1'b1;
         end else begin
            next_s.acc = acc_sum;
         end
      end else begin
         next_s.pre_cnt = s.pre_cnt + 3'h1;
      end

      // receive pin: change taken once the second and third stages agree
      next_s.rx_s = {s.rx_s[1:0], lin_rx};
      if (s.rx_s[1] == s.rx_s[2]) begin
         next_s.rx_stable = s.rx_s[2];
      end

      if (frame_ev.sync_fail && s.slave) begin
         set_err[ERR_SYNC] = 1'b1;
      end
      if (frame_ev.parity_fail && s.slave) begin
         set_err[ERR_PAR] = 1'b1;
      end
      if (frame_ev.tx_active && frame_ev.tx_sample && (s.rx_stable != frame_ev.tx_bit)) begin
         set_err[ERR_BIT] = 1'b1;
      end

      if (s.in_frame && s.bit_tick) begin
         if (s.frame_bits >= max_frame(len)) begin
            set_err[ERR_TIMEOUT_ERROR] = 1'b1;
            next_s.in_frame   = 1'b0;
         end else begin
            next_s.frame_bits = s.frame_bits + 8'h01;
         end
      end
      if (frame_ev.frame_done) begin
         next_s.in_frame  = 1'b0;
         next_s.resp_wait = 1'b0;
         next_s.in_resp   = 1'b0;
      end

      if (s.resp_wait && s.bit_tick) begin
         if (s.resp_bits >= RESP_WAIT_BITS) begin
            set_err[ERR_TIMEOUT_ERROR] = 1'b1;
            next_s.resp_wait  = 1'b0;
            next_s.in_resp    = 1'b0;
         end else begin
            next_s.resp_bits = s.resp_bits + 8'h01;
         end
      end

      if (frame_ev.rx_valid && s.in_resp) begin
         next_s.resp_wait     = 1'b0;
         next_s.first_pending = 1'b0;
         // slave mode: ack or stop needed by first byte
         if (s.first_pending && s.slave && !s.data_acknowledge_bit && !s.stop) begin
            set_err[ERR_TIMEOUT_ERROR] = 1'b1;
         end
         if (s.byte_cnt == len) begin
            if (~s.sum != frame_ev.rx_byte) begin
               set_err[ERR_CHK] = 1'b1;
            end
            next_s.in_resp = 1'b0;
         end else begin
            next_s.sum      = add_carry(s.sum, frame_ev.rx_byte);
            next_s.byte_cnt = s.byte_cnt + 4'h1;
         end
      end

      if (frame_ev.id_done) begin
         next_s.resp_wait     = frame_ev.resp_expected;
         next_s.resp_bits     = 8'h00;
         next_s.in_resp       = frame_ev.resp_expected;
         next_s.first_pending = 1'b1;
         next_s.byte_cnt      = 4'h0;
         next_s.sum           = s.size[SIZE_ENH] ? frame_ev.rx_byte : 8'h00;
      end
      if (frame_ev.frame_start) begin
         next_s.in_frame   = 1'b1;
         next_s.frame_bits = 8'h00;
         next_s.resp_wait  = 1'b0;
         next_s.in_resp    = 1'b0;
         next_s.stop       = 1'b0;
         next_s.data_acknowledge_bit      = 1'b0;
      end

      // flags sticky; a new event outranks clear
      next_s.errf    = (s.errf & ~{5{clr}}) | set_err;
      next_s.err_sum = (s.err_sum & ~clr) | (|set_err);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s       <= '0;
         s.size  <= RST_SIZE;
         s.divlo <= RST_DIV;
         s.scale <= RST_SCALE;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      cfg.bit_tick    = s.bit_tick;
      cfg.enhanced    = s.size[SIZE_ENH];
      cfg.data_len    = len;
      cfg.error_any   = s.err_sum;
      cfg.error_flags = s.errf;
      cfg.slave_mode  = s.slave;
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_err_read;
      avs_read && avs_waitrequest && idx == IDX_ERR ##1 avs_read && !avs_waitrequest;
   endsequence

   sequence s_resp_expire;
      s.resp_wait && s.bit_tick && s.resp_bits >= RESP_WAIT_BITS;
   endsequence

   a_err_upper_zero: assert property (s_err_read |-> avs_readdata[7:5] == 3'h0)
      else $error("error flag upper bits not zero");
   a_sync_slave_set: assert property (frame_ev.sync_fail && s.slave |=> s.errf[ERR_SYNC] && s.err_sum)
      else $error("sync error not flagged");
   a_parity_master_quiet: assert property (!s.slave && !s.errf[ERR_PAR] |=> !s.errf[ERR_PAR])
      else $error("parity flag set outside slave mode");
   a_resp_timeout_set: assert property (s_resp_expire |=> s.errf[ERR_TIMEOUT_ERROR] && !s.resp_wait)
      else $error("missing response not flagged");
   a_frame_timeout_set: assert property (s.in_frame && s.bit_tick && s.frame_bits >= max_frame(len)
      |=> s.errf[ERR_TIMEOUT_ERROR])
      else $error("overlong frame not flagged");
   a_ack_missing_set: assert property (frame_ev.rx_valid && s.in_resp && s.first_pending && s.slave
      && !s.data_acknowledge_bit && !s.stop |=> s.errf[ERR_TIMEOUT_ERROR])
      else $error("missing acknowledge not flagged");
   a_chk_mismatch_set: assert property (frame_ev.rx_valid && s.in_resp && s.byte_cnt == len
      && ~s.sum != frame_ev.rx_byte |=> s.errf[ERR_CHK])
      else $error("checksum mismatch not flagged");
   a_bit_mismatch_set: assert property (frame_ev.tx_active && frame_ev.tx_sample
      && s.rx_stable != frame_ev.tx_bit |=> s.errf[ERR_BIT])
      else $error("bit mismatch not flagged");
   a_classic_seed_zero: assert property (frame_ev.id_done && !s.size[SIZE_ENH] && !frame_ev.frame_start
      |=> s.sum == 8'h00 && s.byte_cnt == 4'h0)
      else $error("classic checksum seed not zero");
   a_len_from_id: assert property (s.size[3:0] == LEN_FROM_ID && s.id[5] |-> cfg.data_len
      == (s.id[4] ? LEN_MAX : LEN_FOUR))
      else $error("identifier length decode wrong");
   a_len_direct: assert property (s.size[3:0] <= LEN_MAX |-> cfg.data_len == s.size[3:0])
      else $error("direct length decode wrong");
   a_flags_hold: assert property (!clr |=> (s.errf & $past(s.errf)) == $past(s.errf))
      else $error("error flag dropped without clear");
   a_clear_summary: assert property (clr && set_err == 5'h00 |=> !s.err_sum && s.errf == 5'h00)
      else $error("clear request did not clear errors");
   a_tick_spacing: assert property (s.bit_tick && s.scale[7:6] != 2'h0 |=> !s.bit_tick)
      else $error("bit ticks closer than prescaler allows");
endmodule : leb_error_baud

/* File: shared/leb_pkg.sv */
// lin error flags, frame length, checksum select and baud configuration: constants and types
// Contract
// - error flag bits 7:5 read zero, ignore writes
// - slave mode: sync tolerance failure sets bit 4
// - slave mode: identifier parity failure sets bit 3
// - master awaiting slave response, none: timeout bit 2
// - slave expecting data, none arrives: timeout
// - frame exceeding maximum length raises timeout
// - no ack/stop before first response byte: timeout (code flags this in slave mode only)
// - received checksum mismatch sets bit 1
// - transmit read-back differs from driven bit: bit 0
// - select bit 7 clear: classic checksum, data only
// - select bit set: enhanced, data plus protected identifier
// - length codes 0..8 give bytes directly; 9..14 reserved
// - length code 1111: length from identifier bits 5:4
// - nine-bit divider: low register plus scale bit 0
// - prescaler held in scale bits 7:6, used
// - multiplier in scale bits 5:1, master only
// - identifier codes 00/01 two, 10 four, 11 eight
// - any error sets summary bit until clear request
package leb_pkg;
   // register indexes; byte address is four times the index
   localparam logic [3:0] IDX_CTRL   = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam logic [3:0] IDX_ERR    = 4'ha;
   localparam logic [3:0] IDX_SIZE   = 4'hb;
   localparam logic [3:0] IDX_DIV    = 4'hc;
   localparam logic [3:0] IDX_SCALE  = 4'hd;
   localparam logic [3:0] IDX_ID     = 4'he;
   // reset values
   localparam logic [7:0] RST_SIZE   = 8'h00;
   localparam logic [7:0] RST_DIV    = 8'hff;
   localparam logic [7:0] RST_SCALE  = 8'hff;
   // error flag positions
   localparam int ERR_SYNC = 4;
   localparam int ERR_PAR  = 3;
   localparam int ERR_TIMEOUT_ERROR = 2;
   localparam int ERR_CHK  = 1;
   localparam int ERR_BIT  = 0;
   // control, status and size bit positions
   localparam int CTL_STOP  = 7;
   localparam int CTL_DATA_ACKNOWLEDGE_BIT = 4;
   localparam int CTL_CLR   = 2;
   localparam int CTL_SLAVE = 0;
   localparam int STS_ERROR = 2;
   localparam int SIZE_ENH  = 7;
   // length codes
   localparam logic [3:0] LEN_FROM_ID = 4'hf;
   localparam logic [3:0] LEN_MAX     = 4'h8;
   localparam logic [3:0] LEN_TWO     = 4'h2;
   localparam logic [3:0] LEN_FOUR    = 4'h4;
   // frame timing in bit times; nominal length stretched by 14/10
   localparam int HDR_BITS  = 34;
   localparam int BYTE_BITS = 10;
   localparam int TOL_NUM   = 14;
   localparam int TOL_DEN   = 10;
   localparam logic [7:0] RESP_WAIT_BITS = 8'h0e;

   typedef struct packed {
      logic       frame_start;
      logic       id_done;
      logic       resp_expected;
      logic       rx_valid;
      logic [7:0] rx_byte;
      logic       frame_done;
      logic       sync_fail;
      logic       parity_fail;
      logic       tx_active;
      logic       tx_sample;
      logic       tx_bit;
   } leb_frame_ev_t;

   typedef struct packed {
      logic       bit_tick;
      logic       enhanced;
      logic [3:0] data_len;
      logic       error_any;
      logic [4:0] error_flags;
      logic       slave_mode;
   } leb_cfg_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
      logic       stop;
      logic       data_acknowledge_bit;
      logic       slave;
      logic [4:0] errf;
      logic       err_sum;
      logic [7:0] size;
      logic [7:0] divlo;
      logic [7:0] scale;
      logic [5:0] id;
      logic [2:0] pre_cnt;
      logic [9:0] acc;
      logic       bit_tick;
      logic [2:0] rx_s;
      logic       rx_stable;
      logic       in_frame;
      logic [7:0] frame_bits;
      logic       resp_wait;
      logic [7:0] resp_bits;
      logic       first_pending;
      logic       in_resp;
      logic [3:0] byte_cnt;
      logic [7:0] sum;
   } leb_state_t;
endpackage : leb_pkg

/* File: bench/leb_node_model.sv */
// far-end lin node and frame engine model: frame events and the bus pin
`timescale 1ns/100ps
module leb_node_model
   import leb_pkg::*;
(
   input  wire logic     sys_clk,
   output leb_frame_ev_t frame_ev,
   output logic          lin_rx
);
   initial begin
      frame_ev = '0;
      lin_rx   = 1'b1;
   end

   // one event stands for exactly one edge, then the lines drop
   task automatic ev(input leb_frame_ev_t e);
      @(posedge sys_clk);
      frame_ev <= e;
      @(posedge sys_clk);
      frame_ev <= '0;
   endtask : ev

   // header, identifier, response bytes with checksum last; gap models a slow sender
   task automatic frame(input logic [7:0] pid, input logic [7:0] b[$], input int gap);
      leb_frame_ev_t e;
      e = '0;
      e.frame_start = 1'b1;
      ev(e);
      e = '0;
      e.id_done = 1'b1;
      e.resp_expected = 1'b1;
      e.rx_byte = pid;
      ev(e);
      foreach (b[i]) begin
         repeat (gap) @(posedge sys_clk);
         e = '0;
         e.rx_valid = 1'b1;
         e.rx_byte = b[i];
         ev(e);
      end
      e = '0;
      e.frame_done = 1'b1;
      ev(e);
   endtask : frame

   // pin level must clear the synchroniser before the read-back sample
   task automatic echo(input logic lvl, input logic drv);
      leb_frame_ev_t e;
      @(posedge sys_clk);
      lin_rx <= lvl;
      repeat (6) @(posedge sys_clk);
      e = '0;
      e.tx_active = 1'b1;
      e.tx_sample = 1'b1;
      e.tx_bit = drv;
      ev(e);
      lin_rx <= 1'b1;
   endtask : echo
endmodule : leb_node_model

/* File: bench/leb_error_baud_bench.sv */
// self-checking bench for lin error flags, length decode, checksum and bit rate
`timescale 1ns/100ps
module leb_error_baud_bench
   import leb_pkg::*;
;
   logic          sys_clk;
   logic          arst_n;
   logic [5:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   leb_frame_ev_t frame_ev;
   leb_frame_ev_t e;
   logic          lin_rx;
   leb_cfg_t      cfg;
   logic [31:0]   exp_q[$];
   logic [7:0]    q[$];
   logic [7:0]    pid;
   int            n;
   int            n_errors;
   int            comparisons;
   logic [31:0]   lens[4] = '{32'h2, 32'h2, 32'h4, 32'h8};
   logic [7:0]    sc[4] = '{8'h3e, 8'h7e, 8'h3f, 8'h3e};
   int            lo[4] = '{199, 99, 99, 6};
   int            hi[4] = '{257, 129, 114, 9};

   leb_error_baud u_leb_error_baud (
      .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_ev(frame_ev),
      .lin_rx(lin_rx), .cfg(cfg)
   );
   leb_node_model u_leb_node_model (.sys_clk(sys_clk), .frame_ev(frame_ev), .lin_rx(lin_rx));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge sys_clk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= w;
      avs_read      <= ~w;
      avs_writedata <= {24'h000000, d};
      // waitrequest is taken as it stood at the edge; release follows that same edge
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++t < 40);
      if (t >= 40) n_errors++;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [3:0] idx, input logic [7:0] x);
      exp_q.push_back({24'h000000, x});
      bus(1'b0, idx, 8'h00);
   endtask : rd

   // read results are matched in order against the notes left by rd
   always @(posedge sys_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         chk(avs_readdata, exp_q.pop_front()); // register value
      end
   end

   function automatic logic [7:0] csum(input logic [7:0] s, input logic [7:0] b[$]);
      logic [8:0] a;
      a = {1'b0, s};
      foreach (b[i]) begin
         a = {1'b0, a[7:0]} + {1'b0, b[i]};
         a = {1'b0, a[7:0]} + {8'h00, a[8]};
      end
      return ~a[7:0];
   endfunction : csum

   task automatic send(input logic enh, input logic bad);
      logic [7:0] c;
      q.delete();
      pid = 8'($urandom_range(254, 1));
      repeat (4) q.push_back(8'($urandom));
      c = csum(enh ? pid : 8'h00, q);
      q.push_back(c ^ {7'h00, bad});
      u_leb_node_model.frame(pid, q, $urandom_range(3, 0));
   endtask : send

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // hang guard: the whole sequence needs well under 25000 cycles
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end

   initial begin
      arst_n        = 1'b0;
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      n_errors      = 0;
      comparisons   = 0;
      void'($urandom(53643));
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(IDX_ERR, 8'h00); // flags zero
      rd(IDX_SIZE, RST_SIZE); // size reset
      rd(IDX_DIV, RST_DIV); // divider reset
      rd(IDX_SCALE, RST_SCALE); // scale reset
      wr(IDX_ERR, 8'hff);
      rd(IDX_ERR, 8'h00); // read only
      wr(IDX_SIZE, 8'hff);
      rd(IDX_SIZE, 8'h8f); // unused bits zero
      wr(4'h3, 8'h5a);
      rd(4'h3, 8'h00);
      done("registers");
      for (int c = 0; c < 9; c++) begin
         wr(IDX_SIZE, 8'(c));
         @(negedge sys_clk);
         chk({28'h0, cfg.data_len}, 32'(c)); // direct code
      end
      wr(IDX_SIZE, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_ID, {2'b00, 2'(i), 4'h5});
         @(negedge sys_clk);
         chk({28'h0, cfg.data_len}, lens[i]); // from identifier
      end
      done("length");
      wr(IDX_DIV, 8'hc8); // divider inside range
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CTRL, {7'h00, i == 3});
         wr(IDX_SCALE, sc[i]);
         n = 0;
         repeat (1600) begin
            @(negedge sys_clk);
            if (cfg.bit_tick === 1'b1) n++;
         end
         chk({31'h0, n >= lo[i] && n <= hi[i]}, 32'h1); // tick count
      end
      wr(IDX_CTRL, 8'h00);
      wr(IDX_SCALE, 8'h3e);
      done("bit rate");
      wr(IDX_SIZE, 8'h04);
      for (int i = 0; i < 4; i++) begin
         send(i[1], i[0]);
         @(negedge sys_clk);
         chk({25'h0, cfg.enhanced, cfg.error_any, cfg.error_flags}, {25'h0, i[1], i[0], 3'h0, i[0], 1'b0});
         rd(IDX_ERR, {6'h00, i[0], 1'b0}); // checksum error flag
         rd(IDX_STATUS, {5'h00, i[0], 2'b00}); // summary
         wr(IDX_CTRL, 8'h04);
         rd(IDX_ERR, 8'h00); // cleared
         rd(IDX_STATUS, 8'h00); // cleared
         if (i == 1) wr(IDX_SIZE, 8'h84);
      end
      done("checksum");
      wr(IDX_CTRL, 8'h01);
      send(1'b1, 1'b0);
      rd(IDX_ERR, 8'h04); // no acknowledge in slave
      wr(IDX_CTRL, 8'h04);
      done("acknowledge");
      e = '0;
      e.sync_fail = 1'b1;
      e.parity_fail = 1'b1;
      u_leb_node_model.ev(e);
      rd(IDX_ERR, 8'h00); // master ignores
      wr(IDX_CTRL, 8'h01);
      @(negedge sys_clk);
      chk({31'h0, cfg.slave_mode}, 32'h1); // slave mode output
      e.parity_fail = 1'b0;
      u_leb_node_model.ev(e);
      rd(IDX_ERR, 8'h10); // sync flag
      e = '0;
      e.parity_fail = 1'b1;
      u_leb_node_model.ev(e);
      rd(IDX_ERR, 8'h18); // parity flag
      wr(IDX_CTRL, 8'h04);
      rd(IDX_ERR, 8'h00); // cleared
      done("slave flags");
      u_leb_node_model.echo(1'b1, 1'b1);
      rd(IDX_ERR, 8'h00); // matching bit
      u_leb_node_model.echo(1'b0, 1'b1);
      rd(IDX_ERR, 8'h01); // mismatch
      wr(IDX_CTRL, 8'h04);
      done("read-back");
      e = '0;
      e.id_done = 1'b1;
      e.resp_expected = 1'b1;
      e.rx_byte = 8'h55;
      u_leb_node_model.ev(e);
      repeat (200) @(posedge sys_clk);
      rd(IDX_ERR, 8'h04); // no response
      e = '0;
      e.frame_done = 1'b1;
      u_leb_node_model.ev(e);
      wr(IDX_CTRL, 8'h04);
      rd(IDX_ERR, 8'h00); // cleared
      e = '0;
      e.frame_start = 1'b1;
      u_leb_node_model.ev(e);
      repeat (900) @(posedge sys_clk);
      rd(IDX_ERR, 8'h04); // overlong frame
      wr(IDX_CTRL, 8'h04);
      rd(IDX_ERR, 8'h00); // cleared
      done("timeout");
      stop_test();
   end
endmodule : leb_error_baud_bench
